// *** hw/icc_clock_unit.sv ***
// module: clock source selection, dividers and register slave
// Summary of operation
// - system clock runs at twice bus clock
// - control one bits 1 and 2 read one
// - bus divider divides by 1, 2, 4, 8
// - debug clock is oscillator divided by two
// - reset enters FLL engaged internal mode
// - reference up to 5 MHz feeds divider
// - nine trim bits adjust internal reference
// - engaged internal: FLL output, debug from FLL
// - engaged external: FLL output, debug from FLL
// - bypassed internal: internal ref out, FLL on
// - internal low power: FLL off, no debug
// - bypassed external: external ref out, FLL on
// - external low power: FLL off, no debug
// - stop: no system nor debug clock
// - source field 7:6, reserved acts as 00
// - reference divider 2**field, resets to 000
// - bit 2 picks internal or external reference
// - bit 1 gates internal reference output
// - bit 0 keeps internal reference in stop if bit 1 is set or the last mode was internal
// - bus divider bits 7:6 reset to 01
// - mode status lags source select via sync
`timescale 1ns/100ps
module icc_clock_unit #(
  parameter bit FIX_BITS = 1'b1
) (
  input  wire logic                 clk_i,     // 50 MHz clock
  input  wire logic                 rst_i,     // sync reset, high
  input  wire icc_pkg::icc_wb_req_s wb_req_i,  // wishbone request
  output icc_pkg::icc_wb_rsp_s      wb_rsp_o,  // wishbone answer
  input  wire icc_pkg::icc_ticks_s  ticks_i,   // raw clock ticks
  input  wire logic                 stop_i,    // stop mode request
  output icc_pkg::icc_clk_out_s     clk_o,     // generated ticks
  output logic                      fll_on_o,  // FLL enabled
  output logic                      iref_on_o, // internal ref runs
  output logic [8:0]                trim_o     // internal ref trim
);

  typedef struct packed {
    icc_pkg::icc_ctrl1_s   c1;
    icc_pkg::icc_ctrl2_s   c2;
    logic [8:0]            trim;
    icc_pkg::icc_src_e     act;
    logic [1:0]            st_s1;
    logic [1:0]            st_s2;
    icc_pkg::icc_mode_e    prev;
    logic                  bus_ph;
    icc_pkg::icc_wb_rsp_s  rsp;
    icc_pkg::icc_clk_out_s out;
    logic                  iref_on;
  } icc_state_s;

  icc_state_s         st_q;
  icc_state_s         st_d;
  icc_pkg::icc_mode_e mode;
  icc_pkg::icc_src_e  want;
  logic               fll_on;
  logic               ref_tick;
  logic               src_tick;
  logic               sys_tick;
  logic               fref_tick;
  logic               dbg_tick;
  logic               wr;
  logic [7:0]         wbyte;

  // ==========================================================
  // decode helpers
  function automatic icc_pkg::icc_src_e eff_src(
    input icc_pkg::icc_src_e s
  );
    eff_src = (s == icc_pkg::SRC_RSV) ? icc_pkg::SRC_FLL : s;
  endfunction

  function automatic icc_pkg::icc_mode_e mode_of(
    input icc_pkg::icc_ctrl1_s c1,
    input icc_pkg::icc_ctrl2_s c2,
    input logic                stp
  );
    icc_pkg::icc_src_e s;
    s = eff_src(c1.clock_source_select);
    if (stp) begin
      mode_of = icc_pkg::MODE_STOP;
    end else begin
      unique case (s)
        icc_pkg::SRC_FLL: begin
          mode_of = c1.fll_reference_choice ? icc_pkg::MODE_FEI
                                            : icc_pkg::MODE_FEE;
        end
        icc_pkg::SRC_INT: begin
          mode_of = c2.low_power ? icc_pkg::MODE_FBIL
                                 : icc_pkg::MODE_FBI;
        end
        default: begin
          mode_of = c2.low_power ? icc_pkg::MODE_FBEL
                                 : icc_pkg::MODE_FBE;
        end
      endcase
    end
  endfunction

  function automatic logic is_int_mode(input icc_pkg::icc_mode_e m);
    is_int_mode = (m == icc_pkg::MODE_FEI) || (m == icc_pkg::MODE_FBI)
               || (m == icc_pkg::MODE_FBIL);
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a[3:2] == o[3:2]);
  endfunction

  // ==========================================================
  // mode and clock path
  assign mode   = mode_of(st_q.c1, st_q.c2, stop_i);
  assign want   = eff_src(st_q.c1.clock_source_select);
  // low power bypass modes and stop turn the FLL off
  assign fll_on = (mode == icc_pkg::MODE_FEI) || (mode == icc_pkg::MODE_FEE)
               || (mode == icc_pkg::MODE_FBI) || (mode == icc_pkg::MODE_FBE);
  assign ref_tick = fll_on && (st_q.c1.fll_reference_choice
                               ? ticks_i.int_ref : ticks_i.ext_ref);

  always_comb begin
    unique case (st_q.act)
      icc_pkg::SRC_INT: src_tick = ticks_i.int_ref;
      icc_pkg::SRC_EXT: src_tick = ticks_i.ext_ref;
      default:          src_tick = ticks_i.controlled_oscillator;
    endcase
  end

  icc_tick_div #(.SEL_W(icc_pkg::REFERENCE_DIVIDER_SELECT_W)) u_ref_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (ref_tick),
    .sel_i  (st_q.c1.reference_divider_select),
    .tick_o (fref_tick)
  );

  icc_tick_div #(.SEL_W(icc_pkg::BUS_DIVIDER_SELECT_W)) u_bus_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (src_tick && !stop_i),
    .sel_i  (st_q.c2.bus_divider_select),
    .tick_o (sys_tick)
  );

  // fixed select of one gives the constant halving of the oscillator
  icc_tick_div #(.SEL_W(1)) u_dbg_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (ticks_i.controlled_oscillator && fll_on),
    .sel_i  (1'b1),
    .tick_o (dbg_tick)
  );

  // ==========================================================
  // next state
  // registers load at the edge where the master samples ack high
  assign wr    = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we
              && st_q.rsp.ack && wb_req_i.sel[0];
  assign wbyte = wb_req_i.dat[7:0];

  always_comb begin
    st_d = st_q;
    // single cycle answer; ack drops the cycle after it was given
    st_d.rsp.ack = wb_req_i.cyc && wb_req_i.stb && !st_q.rsp.ack;
    st_d.rsp.dat = '0;
    if (hit(wb_req_i.adr, icc_pkg::OFF_CTRL1)) begin
      st_d.rsp.dat[7:0] = st_q.c1;
      if (FIX_BITS) begin
        st_d.rsp.dat[7:0] = st_q.c1 | icc_pkg::CTRL1_FIX;
      end
    end else if (hit(wb_req_i.adr, icc_pkg::OFF_CTRL2)) begin
      st_d.rsp.dat[7:0] = st_q.c2;
    end else if (hit(wb_req_i.adr, icc_pkg::OFF_STAT)) begin
      st_d.rsp.dat[icc_pkg::STAT_LSB +: 2] = st_q.st_s2;
    end else if (hit(wb_req_i.adr, icc_pkg::OFF_TRIM)) begin
      st_d.rsp.dat[8:0] = st_q.trim;
    end
    if (!wb_req_i.we || !st_d.rsp.ack) begin
      st_d.rsp.dat = st_d.rsp.ack ? st_d.rsp.dat : '0;
    end else begin
      st_d.rsp.dat = '0;
    end

    if (wr && hit(wb_req_i.adr, icc_pkg::OFF_CTRL1)) begin
      st_d.c1 = wbyte;
      if (FIX_BITS) begin
        st_d.c1 = wbyte | icc_pkg::CTRL1_FIX;
      end
    end
    if (wr && hit(wb_req_i.adr, icc_pkg::OFF_CTRL2)) begin
      st_d.c2 = wbyte;
    end
    if (wr && hit(wb_req_i.adr, icc_pkg::OFF_TRIM)) begin
      st_d.trim = wb_req_i.dat[8:0];
    end

    // swap source only after the old one completes a period or while stopped
    if (want != st_q.act && (sys_tick || stop_i)) begin
      st_d.act = want;
    end
    st_d.st_s1 = st_q.act;
    st_d.st_s2 = st_q.st_s1;

    if (mode != icc_pkg::MODE_STOP) begin
      st_d.prev = mode;
    end
    // internal reference must survive stop only when asked
    st_d.iref_on = !stop_i || (st_q.c1.internal_ref_stop_keep
                   && (st_q.c1.internal_ref_output_enable
                       || is_int_mode(st_q.prev)));

    if (sys_tick) begin
      st_d.bus_ph = !st_q.bus_ph;
    end
    st_d.out.sys     = sys_tick;
    st_d.out.bus     = sys_tick && st_q.bus_ph;
    st_d.out.dbg     = dbg_tick;
    st_d.out.fll_ref = fref_tick;
    st_d.out.int_ref = ticks_i.int_ref && st_d.iref_on
                    && st_q.c1.internal_ref_output_enable;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q         <= '0;
      st_q.c1      <= icc_pkg::CTRL1_RST;
      st_q.c2      <= icc_pkg::CTRL2_RST;
      st_q.trim    <= icc_pkg::TRIM_RST;
      st_q.act     <= icc_pkg::SRC_FLL;
      st_q.prev    <= icc_pkg::MODE_FEI;
      st_q.iref_on <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_rsp_o  = st_q.rsp;
  assign clk_o     = st_q.out;
  assign fll_on_o  = fll_on;
  assign iref_on_o = st_q.iref_on;
  assign trim_o    = st_q.trim;

  // ==========================================================
  // checks
  property p_fix_bits;
    @(posedge clk_i) disable iff (rst_i)
      wb_rsp_o.ack && !wb_req_i.we
      && hit(wb_req_i.adr, icc_pkg::OFF_CTRL1) && FIX_BITS
      |-> wb_rsp_o.dat[2:1] == 2'b11;
  endproperty
  a_fix_bits: assert property (p_fix_bits)
    else $error("control one bits 1 and 2 not read as one");

  property p_bus_half;
    @(posedge clk_i) disable iff (rst_i)
      clk_o.bus |-> clk_o.sys && !st_q.bus_ph;
  endproperty
  a_bus_half: assert property (p_bus_half)
    else $error("bus tick not on every second system tick");

  property p_reset_mode;
    @(posedge clk_i)
      rst_i && !stop_i ##1 !stop_i |-> mode == icc_pkg::MODE_FEI;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("reset did not enter engaged internal mode");

  property p_dbg_src;
    @(posedge clk_i) disable iff (rst_i)
      clk_o.dbg |-> $past(ticks_i.controlled_oscillator) && $past(fll_on);
  endproperty
  a_dbg_src: assert property (p_dbg_src)
    else $error("debug tick without oscillator tick");

  property p_stop_quiet;
    @(posedge clk_i) disable iff (rst_i)
      stop_i |=> !clk_o.sys && !clk_o.dbg && !clk_o.fll_ref;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("clock output seen in stop");

  property p_lowpower;
    @(posedge clk_i) disable iff (rst_i)
      (mode == icc_pkg::MODE_FBIL || mode == icc_pkg::MODE_FBEL)
      |=> !clk_o.dbg && !clk_o.fll_ref;
  endproperty
  a_lowpower: assert property (p_lowpower)
    else $error("FLL active in low power bypass");

  property p_iref_gate;
    @(posedge clk_i) disable iff (rst_i)
      clk_o.int_ref |-> $past(st_q.c1.internal_ref_output_enable)
                     && $past(ticks_i.int_ref);
  endproperty
  a_iref_gate: assert property (p_iref_gate)
    else $error("internal reference output while disabled");

  property p_status_lag;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) && !$past(rst_i, 2)
      |-> st_q.st_s2 == $past(st_q.act, 2);
  endproperty
  a_status_lag: assert property (p_status_lag)
    else $error("mode status not two cycles behind source");

  property p_clean_swap;
    @(posedge clk_i) disable iff (rst_i)
      !$stable(st_q.act) |-> $past(sys_tick) || $past(stop_i);
  endproperty
  a_clean_swap: assert property (p_clean_swap)
    else $error("source swapped mid period");

endmodule

// *** hw/icc_tick_div.sv ***
// module: power-of-two divider of a tick stream
`timescale 1ns/100ps
module icc_tick_div #(
  parameter int unsigned SEL_W = 3
) (
  input  wire logic             clk_i,   // system clock
  input  wire logic             rst_i,   // sync reset, high
  input  wire logic             tick_i,  // source tick
  input  wire logic [SEL_W-1:0] sel_i,   // divide by 2**sel_i
  output logic                  tick_o   // divided tick
);

  localparam int unsigned CNT_W = (1 << SEL_W) - 1;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } icc_div_s;

  icc_div_s        st_q;
  icc_div_s        st_d;
  logic [CNT_W-1:0] mask;

  // ==========================================================
  // terminal count follows the select, so a new ratio acts at once
  always_comb begin
    for (int i = 0; i < CNT_W; i++) begin
      mask[i] = (i < int'(sel_i));
    end
    tick_o = tick_i && ((st_q.cnt & mask) == mask);
    st_d   = st_q;
    if (tick_i) begin
      st_d.cnt = tick_o ? '0 : st_q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// *** inc/icc_pkg.sv ***
// package: register map, fields, modes and carriers of the clock unit
package icc_pkg;

  // ==========================================================
  // clock and reference limits
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned REF_MAX_HZ  = 5_000_000;
  localparam int unsigned REF_MIN_CYC = CLK_HZ / REF_MAX_HZ;

  // ==========================================================
  // register map (byte addresses on the bus)
  localparam logic [3:0] OFF_CTRL1 = 4'h0;
  localparam logic [3:0] OFF_CTRL2 = 4'h4;
  localparam logic [3:0] OFF_STAT  = 4'h8;
  localparam logic [3:0] OFF_TRIM  = 4'hc;

  localparam int unsigned REFERENCE_DIVIDER_SELECT_W  = 3;
  localparam int unsigned BUS_DIVIDER_SELECT_W  = 2;
  localparam int unsigned TRIM_W  = 9;
  localparam int unsigned STAT_LSB = 2;

  localparam logic [7:0] CTRL1_RST = 8'h06;
  localparam logic [7:0] CTRL2_RST = 8'h40;
  localparam logic [7:0] CTRL1_FIX = 8'h06;
  localparam logic [TRIM_W-1:0] TRIM_RST = 9'h100;

  // ==========================================================
  // field layouts
  typedef enum logic [1:0] {
    SRC_FLL = 2'b00,
    SRC_INT = 2'b01,
    SRC_EXT = 2'b10,
    SRC_RSV = 2'b11
  } icc_src_e;

  typedef struct packed {
    icc_src_e            clock_source_select;
    logic [REFERENCE_DIVIDER_SELECT_W-1:0]   reference_divider_select;
    logic                fll_reference_choice;
    logic                internal_ref_output_enable;
    logic                internal_ref_stop_keep;
  } icc_ctrl1_s;

  typedef struct packed {
    logic [BUS_DIVIDER_SELECT_W-1:0]   bus_divider_select;
    logic                ext_range;
    logic                ext_high_gain;
    logic                low_power;
    logic                ext_osc_request;
    logic                ext_ref_output_enable;
    logic                ext_ref_stop_keep;
  } icc_ctrl2_s;

  typedef enum logic [2:0] {
    MODE_FEI  = 3'b000,
    MODE_FEE  = 3'b001,
    MODE_FBI  = 3'b010,
    MODE_FBIL = 3'b011,
    MODE_FBE  = 3'b100,
    MODE_FBEL = 3'b101,
    MODE_STOP = 3'b110
  } icc_mode_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } icc_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } icc_wb_rsp_s;

  // one-cycle pulses, one per period of each raw clock
  typedef struct packed {
    logic int_ref;
    logic ext_ref;
    logic controlled_oscillator;
  } icc_ticks_s;

  typedef struct packed {
    logic sys;
    logic bus;
    logic dbg;
    logic int_ref;
    logic fll_ref;
  } icc_clk_out_s;

endpackage

// *** sim/icc_tick_gen.sv ***
// partner model: raw oscillator ticks feeding the clock unit
`timescale 1ns/100ps
module icc_tick_gen #(
  parameter int unsigned INT_P = 11, // internal reference period, cycles
  parameter int unsigned EXT_P = 13, // external reference period, cycles
  parameter int unsigned DCO_P = 3   // oscillator period, cycles
) (
  input  wire logic           clk_i,   // system clock
  input  wire logic           rst_i,   // sync reset, high
  output icc_pkg::icc_ticks_s ticks_o  // one-cycle ticks
);
  // ==========================================================
  // free running periods; references never faster than 5 MHz
  int unsigned ci, ce, cd;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ci <= 0;
      ce <= 0;
      cd <= 0;
      ticks_o <= '0;
    end else begin
      ci <= (ci + 1 == INT_P) ? 0 : ci + 1;
      ce <= (ce + 1 == EXT_P) ? 0 : ce + 1;
      cd <= (cd + 1 == DCO_P) ? 0 : cd + 1;
      ticks_o.int_ref <= (ci == 0);
      ticks_o.ext_ref <= (ce == 0);
      ticks_o.controlled_oscillator <= (cd == 0);
    end
  end
endmodule

// *** sim/test_internal_clock_source_ctrl.sv ***
// testbench: registers, source modes, dividers and stop of the clock unit
`timescale 1ns/100ps
module test_internal_clock_source_ctrl;
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [1:0] src;
    logic       fll;
  } icc_row_s;
  localparam icc_row_s ROWS [9] = '{
    '{8'h00, 8'h00, 2'h0, 1'b1}, '{8'h08, 8'h40, 2'h0, 1'b1},
    '{8'h10, 8'h80, 2'h0, 1'b1}, '{8'h18, 8'hc0, 2'h0, 1'b1},
    '{8'hc0, 8'h00, 2'h0, 1'b1}, '{8'h40, 8'h00, 2'h1, 1'b1},
    '{8'h40, 8'h08, 2'h1, 1'b0}, '{8'h80, 8'h40, 2'h2, 1'b1},
    '{8'h80, 8'h48, 2'h2, 1'b0}};
  logic                 clk_i;
  logic                 rst_i;
  logic                 stop_i;
  icc_pkg::icc_wb_req_s req;
  icc_pkg::icc_wb_rsp_s rsp;
  icc_pkg::icc_ticks_s  ticks;
  icc_pkg::icc_clk_out_s clk_o;
  logic                 fll_on, iref_on;
  logic [8:0]           trim;
  logic [31:0]          q;
  logic                 cnt_en;
  int n_dco, n_int, n_ext, n_sys, n_bus, n_dbg, n_ref, n_iro;
  int mismatches, check_count, cyc_n;

  icc_clock_unit icc_clock_unit_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_rsp_o(rsp), .ticks_i(ticks), .stop_i(stop_i),
    .clk_o(clk_o), .fll_on_o(fll_on), .iref_on_o(iref_on), .trim_o(trim));
  icc_tick_gen icc_tick_gen_i (.clk_i(clk_i), .rst_i(rst_i),
    .ticks_o(ticks));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ==========================================================
  // pulse counters over a measuring window
  always @(posedge clk_i) begin
    if (cnt_en) begin
      n_dco += ticks.controlled_oscillator;
      n_int += ticks.int_ref;
      n_ext += ticks.ext_ref;
      n_sys += clk_o.sys;
      n_bus += clk_o.bus;
      n_dbg += clk_o.dbg;
      n_ref += clk_o.fll_ref;
      n_iro += clk_o.int_ref;
    end
  end

  // hang guard: whole run needs roughly 20k cycles
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // window edges cut at most one pulse either way
  function automatic int near(int g, int e);
    return (g >= e - 1 && g <= e + 1) ? e : g;
  endfunction

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
    // no limit of its own: only the hang guard ends a missing answer
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [3:0] a);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
  endtask

  task automatic measure();
    repeat (200) @(posedge clk_i);
    {n_dco, n_int, n_ext, n_sys, n_bus, n_dbg, n_ref, n_iro} = '0;
    cnt_en <= 1'b1;
    repeat (1400) @(posedge clk_i);
    cnt_en <= 1'b0;
    @(posedge clk_i);
  endtask

  initial begin
    int src_n;
    int e_dbg;
    int e_ref;
    logic [1:0] b;
    rst_i = 1'b1;
    stop_i = 1'b0;
    req = '0;
    cnt_en = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // ==========================================================
    // table of source, divider and power modes
    for (int i = 0; i < 9; i++) begin
      // scaled model rates: the divider only needs a fixed ratio here
      wr(icc_pkg::OFF_CTRL1, {24'h0000_00, ROWS[i].c1});
      wr(icc_pkg::OFF_CTRL2, {24'h0000_00, ROWS[i].c2});
      measure();
      b = ROWS[i].c2[7:6];
      src_n = (ROWS[i].src == 2'h0 ? n_dco :
               ROWS[i].src == 2'h1 ? n_int : n_ext) >> b;
      e_dbg = ROWS[i].fll ? n_dco / 2 : 0;
      e_ref = ROWS[i].fll ? n_int >> ROWS[i].c1[5:3] : 0;
      check("sys", src_n, near(n_sys, src_n));
      check("bus", n_sys / 2, near(n_bus, n_sys / 2));
      check("dbg", e_dbg, near(n_dbg, e_dbg));
      check("fll_ref", e_ref, near(n_ref, e_ref));
      check("fll_on", ROWS[i].fll, fll_on);
      rd(icc_pkg::OFF_STAT);
      check("status", {ROWS[i].src, 2'h0}, q & 32'h0000_000c);
      rd(icc_pkg::OFF_CTRL1);
      check("ctrl1", ROWS[i].c1 | 8'h06, q);
      $display("mode row %0d done", i);
    end
    // ==========================================================
    // stop with and without the keep bit
    wr(icc_pkg::OFF_CTRL1, 32'h0000_0001);
    repeat (300) @(posedge clk_i);
    stop_i <= 1'b1;
    measure();
    check("stop_sys", 0, n_sys);
    check("stop_dbg", 0, n_dbg);
    check("stop_fll", 1'b0, fll_on);
    check("stop_iref", 1'b1, iref_on);
    wr(icc_pkg::OFF_CTRL1, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    check("stop_iref_off", 1'b0, iref_on);
    stop_i <= 1'b0;
    measure();
    check("wake_sys", n_dco >> 1, near(n_sys, n_dco >> 1));
    $display("stop test done");
    // ==========================================================
    // second reset in mid-run, then register access corners
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("trim_o", 9'h100, trim);
    check("iref_on", 1'b1, iref_on);
    rd(icc_pkg::OFF_CTRL1);
    check("ctrl1_rst", 8'h06, q);
    rd(icc_pkg::OFF_CTRL2);
    check("ctrl2_rst", 8'h40, q);
    rd(icc_pkg::OFF_STAT);
    check("stat_rst", 8'h00, q);
    wr(icc_pkg::OFF_TRIM, 32'h0000_01ff);
    @(posedge clk_i);
    check("trim_w", 9'h1ff, trim);
    wb(1'b1, icc_pkg::OFF_CTRL2, 32'h0000_00c0, 4'h0);
    rd(icc_pkg::OFF_CTRL2);
    check("ctrl2_nosel", 8'h40, q);
    wr(icc_pkg::OFF_STAT, 32'h0000_000c);
    rd(icc_pkg::OFF_STAT);
    check("stat_ro", 8'h00, q & 32'h0000_000c);
    measure();
    check("rst_sys", n_dco >> 1, near(n_sys, n_dco >> 1));
    check("rst_ref", n_int, near(n_ref, n_int));
    check("iref_out", n_int, near(n_iro, n_int));
    $display("reset test done");
    end_of_test();
  end
endmodule
